// *** design/dac_host_pkg.sv ***
// constants shared by the parallel-load converter host controller
`default_nettype none
package dac_host_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned CHAN_SEL_W      = 2;
  localparam logic [1:0]  CHAN_A          = 2'h0;
  localparam logic [1:0]  CHAN_B          = 2'h1;
  localparam logic [1:0]  CHAN_C          = 2'h2;
  localparam logic [1:0]  CHAN_D          = 2'h3;
  localparam int unsigned LOW_BYTE_W      = 8;
  localparam int unsigned HIGH_BYTE_LSB   = 8;
  localparam logic        GAIN_UNITY      = 1'b0;
  localparam logic        GAIN_DOUBLE     = 1'b1;
  localparam int unsigned SETUP_NS        = 8;
  localparam int unsigned STROBE_NS       = 20;
  localparam int unsigned HOLD_NS         = 8;
  localparam int unsigned UPDATE_NS       = 20;
  localparam int unsigned WAKE_5V_NS      = 2500;
  localparam int unsigned WAKE_3V_NS      = 5000;
  // least times round up
  localparam int unsigned SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYC   = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned UPDATE_CYC = (UPDATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_CYC   = (WAKE_3V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W      = 12;
endpackage
`default_nettype wire

// *** design/dac_pin_if.sv ***
// pin bundle between the sequencer and the pin output stage
`default_nettype none
interface dac_pin_if #(parameter int unsigned BUS_W = 16);
  logic             chip_select_n;
  logic             write_strobe_n;
  logic [1:0]       channel_sel;
  logic [BUS_W-1:0] bus;
  logic             upper_byte_select;
  logic             output_update_n;
  logic             clear_n;
  logic             power_down_n;
  modport drv (output chip_select_n, write_strobe_n, channel_sel, bus, upper_byte_select,
               output_update_n, clear_n, power_down_n);
  modport reg_side (input chip_select_n, write_strobe_n, channel_sel, bus, upper_byte_select,
                    output_update_n, clear_n, power_down_n);
endinterface
`default_nettype wire

// *** design/dac_pin_reg.sv ***
// registered pin stage: every pin driven to the converter comes from a flip-flop
`default_nettype none
module dac_pin_reg #(
  parameter int unsigned BUS_W = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_ce,
  dac_pin_if.reg_side           pins,
  output logic                  o_cs_n,
  output logic                  o_wr_n,
  output logic [1:0]            o_chan_sel,
  output logic [BUS_W-1:0]      o_bus,
  output logic                  o_upper_byte_select,
  output logic                  o_output_update_n,
  output logic                  o_clear_n,
  output logic                  o_power_down_n
);
  // reset leaves strobes idle, power applied, clear released
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_cs_n              <= 1'b1;
      o_wr_n              <= 1'b1;
      o_chan_sel          <= 2'h0;
      o_bus               <= '0;
      o_upper_byte_select <= 1'b0;
      o_output_update_n   <= 1'b1;
      o_clear_n           <= 1'b1;
      o_power_down_n      <= 1'b1;
    end else if (i_ce) begin
      o_cs_n              <= pins.chip_select_n;
      o_wr_n              <= pins.write_strobe_n;
      o_chan_sel          <= pins.channel_sel;
      o_bus               <= pins.bus;
      o_upper_byte_select <= pins.upper_byte_select;
      o_output_update_n   <= pins.output_update_n;
      o_clear_n           <= pins.clear_n;
      o_power_down_n      <= pins.power_down_n;
    end
  end
endmodule // dac_pin_reg
`default_nettype wire

// *** design/dac_host_ctrl.sv ***
// host controller that writes a quad parallel-load converter through its pins
`default_nettype none
// Function
// - channel bits 00..11 pick A..D
// - write all, then one update pulse
// - write both bytes before update
// - gain rides unused upper bus line in word mode only; byte mode drives no gain
// - full-word bus at least ten bits
module dac_host_ctrl #(
  parameter int unsigned DATA_W    = 10,
  parameter int unsigned BUS_W     = 16,
  parameter bit          BYTE_MODE = 1'b0,
  parameter int unsigned GAIN_LINE = 15,
  parameter int unsigned WAKE_CYC  = dac_host_pkg::WAKE_CYC
) (
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  input  wire logic              i_ce,
  input  wire logic              i_wr_valid,
  input  wire logic [1:0]        i_wr_chan,
  input  wire logic [DATA_W-1:0] i_wr_data,
  input  wire logic              i_wr_gain,
  input  wire logic              i_sync_mode,
  input  wire logic              i_update_req,
  input  wire logic              i_clear_req,
  input  wire logic              i_power_down,
  output logic                   o_wr_ready,
  output logic                   o_busy,
  output logic                   o_awake,
  output logic                   o_cs_n,
  output logic                   o_wr_n,
  output logic [1:0]             o_chan_sel,
  output logic [BUS_W-1:0]       o_bus,
  output logic                   o_upper_byte_select,
  output logic                   o_output_update_n,
  output logic                   o_clear_n,
  output logic                   o_power_down_n
);
  typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_UPDATE, ST_CLEAR} state_t;

  localparam logic [dac_host_pkg::CNT_W-1:0] SETUP_N  =
    dac_host_pkg::CNT_W'(dac_host_pkg::SETUP_CYC);
  localparam logic [dac_host_pkg::CNT_W-1:0] STROBE_N =
    dac_host_pkg::CNT_W'(dac_host_pkg::STROBE_CYC);
  localparam logic [dac_host_pkg::CNT_W-1:0] HOLD_N   =
    dac_host_pkg::CNT_W'(dac_host_pkg::HOLD_CYC);
  localparam logic [dac_host_pkg::CNT_W-1:0] UPDATE_N =
    dac_host_pkg::CNT_W'(dac_host_pkg::UPDATE_CYC);

  state_t                          state_q;
  logic [dac_host_pkg::CNT_W-1:0]  cnt_q;
  logic [1:0]                      chan_q;
  logic [DATA_W-1:0]               data_q;
  logic                            gain_q;
  logic                            high_q;
  logic                            pending_q;
  logic                            sync_q;
  logic [31:0]                     wake_q;
  logic                            pd_q;
  logic                            cnt_done;

  dac_pin_if #(.BUS_W(BUS_W)) pins ();

  assign cnt_done   = (cnt_q == '0);
  assign o_wr_ready = (state_q == ST_IDLE) && !i_clear_req && !i_update_req;
  assign o_busy     = (state_q != ST_IDLE) || pending_q;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q   <= ST_IDLE;
      cnt_q     <= '0;
      chan_q    <= 2'h0;
      data_q    <= '0;
      gain_q    <= dac_host_pkg::GAIN_UNITY;
      high_q    <= 1'b0;
      pending_q <= 1'b0;
      sync_q    <= 1'b0;
    end else if (i_ce) begin
      case (state_q)
        ST_IDLE: begin
          if (i_clear_req) begin
            state_q <= ST_CLEAR;
            cnt_q   <= UPDATE_N;
          end else if (i_update_req) begin
            state_q <= ST_UPDATE;
            cnt_q   <= UPDATE_N;
          end else if (i_wr_valid) begin
            chan_q    <= i_wr_chan;
            data_q    <= i_wr_data;
            gain_q    <= i_wr_gain;
            sync_q    <= i_sync_mode;
            high_q    <= 1'b0;
            pending_q <= BYTE_MODE;
            state_q   <= ST_SETUP;
            cnt_q     <= SETUP_N;
          end
        end
        ST_SETUP: begin
          if (cnt_done) begin
            state_q <= ST_STROBE;
            cnt_q   <= STROBE_N;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ST_STROBE: begin
          // rising strobe edge at exit is the capture point of the device
          if (cnt_done) begin
            state_q <= ST_HOLD;
            cnt_q   <= HOLD_N;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ST_HOLD: begin
          if (!cnt_done) begin
            cnt_q <= cnt_q - 1'b1;
          end else if (BYTE_MODE && !high_q) begin
            high_q  <= 1'b1;
            state_q <= ST_SETUP;
            cnt_q   <= SETUP_N;
          end else begin
            pending_q <= 1'b0;
            state_q   <= ST_IDLE;
          end
        end
        ST_UPDATE, ST_CLEAR: begin
          if (cnt_done) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // power-down pin and wake-time counter; registers survive on the device side
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pd_q   <= 1'b0;
      wake_q <= '0;
    end else if (i_ce) begin
      pd_q <= i_power_down;
      if (i_power_down) begin
        wake_q <= WAKE_CYC;
      end else if (wake_q != '0) begin
        wake_q <= wake_q - 32'h1;
      end
    end
  end
  assign o_awake = !pd_q && (wake_q == '0);

  // pin drive; bus lines follow word or byte layout
  always_comb begin
    pins.chip_select_n     = !(state_q inside {ST_SETUP, ST_STROBE, ST_HOLD});
    pins.write_strobe_n    = (state_q != ST_STROBE);
    pins.channel_sel       = chan_q;
    pins.upper_byte_select = BYTE_MODE && high_q;
    pins.bus               = '0;
    if (BYTE_MODE) begin
      if (high_q) begin
        pins.bus[DATA_W-dac_host_pkg::HIGH_BYTE_LSB-1:0] =
          data_q[DATA_W-1:dac_host_pkg::HIGH_BYTE_LSB];
      end else begin
        pins.bus[dac_host_pkg::LOW_BYTE_W-1:0] = data_q[dac_host_pkg::LOW_BYTE_W-1:0];
      end
    end else begin
      pins.bus[DATA_W-1:0]  = data_q;
      pins.bus[GAIN_LINE]   = gain_q;
    end
    // sync mode: update low in the hold of the last byte, so a byte pair loads whole
    pins.output_update_n = !((state_q == ST_UPDATE) ||
                             (sync_q && state_q == ST_HOLD &&
                              (!BYTE_MODE || high_q)));
    pins.clear_n         = (state_q != ST_CLEAR);
    pins.power_down_n    = !pd_q;
  end

  dac_pin_reg #(.BUS_W(BUS_W)) u_pins (
    .i_clk               (i_clk),
    .i_resetn            (i_resetn),
    .i_ce                (i_ce),
    .pins                (pins),
    .o_cs_n              (o_cs_n),
    .o_wr_n              (o_wr_n),
    .o_chan_sel          (o_chan_sel),
    .o_bus               (o_bus),
    .o_upper_byte_select (o_upper_byte_select),
    .o_output_update_n   (o_output_update_n),
    .o_clear_n           (o_clear_n),
    .o_power_down_n      (o_power_down_n)
  );

  a_strobe_needs_cs: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !o_wr_n |-> !o_cs_n) else $error("strobe low without chip select");
  a_strobe_width: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $fell(o_wr_n) && i_ce |-> !o_wr_n [*5]) else $error("strobe too short");
  a_chan_stable: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !o_cs_n && $past(!o_cs_n) |-> $stable(o_chan_sel)) else $error("channel moved");
  a_no_update_in_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !o_wr_n |-> o_output_update_n) else $error("update during strobe");
  a_clear_alone: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !o_clear_n |-> o_cs_n) else $error("write during clear");
  a_pd_follows: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && $past(i_ce) && $past(i_ce, 2) |-> o_power_down_n == !$past(i_power_down, 2))
    else $error("power down pin lag");
  a_byte_high_top: assert property (@(posedge i_clk) disable iff (!i_resetn)
    BYTE_MODE && o_upper_byte_select |-> o_bus[BUS_W-1:2] == '0)
    else $error("high byte carries extra lines");
  a_byte_order: assert property (@(posedge i_clk) disable iff (!i_resetn)
    BYTE_MODE && !o_output_update_n |-> !pending_q || high_q)
    else $error("update mid word");
  c_write: cover property (@(posedge i_clk) $rose(o_wr_n) && !o_cs_n);
  c_update: cover property (@(posedge i_clk) $fell(o_output_update_n));
  c_clear: cover property (@(posedge i_clk) $fell(o_clear_n));
  c_wake: cover property (@(posedge i_clk) $rose(o_awake));
endmodule // dac_host_ctrl
`default_nettype wire

// *** tb/dac_dev_model.sv ***
// behavioural model of the quad parallel-load converter seen at its pins
`default_nettype none
module dac_dev_model #(
  parameter int unsigned BUS_W     = 16,
  parameter int unsigned DATA_W    = 10,
  parameter int unsigned GAIN_LINE = 15,
  parameter bit          BYTE_MODE = 1'b0
) (
  input wire logic             i_clk,
  input wire logic             i_cs_n,
  input wire logic             i_wr_n,
  input wire logic [1:0]       i_chan_sel,
  input wire logic [BUS_W-1:0] i_bus,
  input wire logic             i_upper_byte_select,
  input wire logic             i_update_n,
  input wire logic             i_clear_n,
  input wire logic             i_power_down_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] in_q [4];
  logic [DATA_W-1:0] dac_q [4];
  logic              gin_q [4];
  logic              gain_q [4];
  logic              dirty_q [4];
  logic              wr_prev_q;
  logic              out_hiz;
  int                n_reload;
  assign out_hiz = !i_power_down_n;
  task automatic zero_all();
    for (int k = 0; k < 4; k++) begin
      in_q[k] = '0;
      dac_q[k] = '0;
      gin_q[k] = 1'b0;
      gain_q[k] = 1'b0;
      dirty_q[k] = 1'b0;
    end
  endtask
  initial begin
    n_reload = 0;
    wr_prev_q = 1'b1;
    zero_all();
  end
  // pins are sampled on the bench clock, which is safe only because the host holds them for cycles
  always @(posedge i_clk or negedge i_clear_n) begin
    if (!i_clear_n) begin
      zero_all();
    end else begin
      wr_prev_q <= i_wr_n;
      // the power pin is never looked at here, so contents survive power-down
      if (!i_cs_n && i_wr_n && !wr_prev_q) begin
        if (!BYTE_MODE) begin
          in_q[i_chan_sel] <= i_bus[DATA_W-1:0];
          gin_q[i_chan_sel] <= i_bus[GAIN_LINE];
        end else if (i_upper_byte_select) begin
          in_q[i_chan_sel][DATA_W-1:8] <= i_bus[DATA_W-9:0];
        end else begin
          in_q[i_chan_sel][7:0] <= i_bus[7:0];
        end
        dirty_q[i_chan_sel] <= 1'b1;
      end
      if (!i_update_n) begin
        for (int k = 0; k < 4; k++) begin
          if (dirty_q[k]) begin
            dac_q[k] <= in_q[k];
            gain_q[k] <= gin_q[k];
            dirty_q[k] <= 1'b0;
            n_reload++;
          end
        end
      end
    end
  end
endmodule // dac_dev_model
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the parallel-load converter host controller
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] VALS [4] = '{10'h2A5, 10'h15A, 10'h3FF, 10'h001};
  localparam logic       GAINS [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  localparam int         WAKE_SIM = 4;
  logic        ce = 1'b1;
  logic        i_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        wr_valid = 1'b0;
  logic        sync_mode = 1'b0;
  logic        upd = 1'b0;
  logic        clr = 1'b0;
  logic        pdn = 1'b0;
  logic        gain = 1'b0;
  logic [1:0]  chan = 2'h0;
  logic [9:0]  data = 10'h000;
  logic        rdy, busy, awake, cs_n, wr_n, ubs, upd_n, clr_n, pd_n;
  logic [1:0]  csel;
  logic [15:0] bus;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          base;
  always #2 i_clk = ~i_clk;
  // widths, word layout and gain line stay at their defaults; only the wake count is shortened
  dac_host_ctrl #(.WAKE_CYC(WAKE_SIM)) u_dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(ce), .i_wr_valid(wr_valid), .i_wr_chan(chan),
    .i_wr_data(data), .i_wr_gain(gain), .i_sync_mode(sync_mode), .i_update_req(upd),
    .i_clear_req(clr), .i_power_down(pdn), .o_wr_ready(rdy), .o_busy(busy), .o_awake(awake),
    .o_cs_n(cs_n), .o_wr_n(wr_n), .o_chan_sel(csel), .o_bus(bus), .o_upper_byte_select(ubs),
    .o_output_update_n(upd_n), .o_clear_n(clr_n), .o_power_down_n(pd_n));
  dac_dev_model u_dev (
    .i_clk(i_clk), .i_cs_n(cs_n), .i_wr_n(wr_n), .i_chan_sel(csel), .i_bus(bus),
    .i_upper_byte_select(ubs), .i_update_n(upd_n), .i_clear_n(clr_n), .i_power_down_n(pd_n));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // waits for idle with the registered pins back at rest; a hang counts as a mismatch
  task automatic settle();
    int k;
    k = 0;
    while (!(rdy === 1'b1 && cs_n === 1'b1 && upd_n === 1'b1 && clr_n === 1'b1) && k < 200) begin
      @(posedge i_clk);
      k++;
    end
    if (k == 200) begin
      n_fail++;
      $display("ERROR settle expected idle seen busy");
    end
    repeat (2) @(posedge i_clk);
  endtask
  // kind 0 write, 1 update pulse, 2 clear pulse; the level drops at the edge that takes it
  task automatic go(input int kind);
    @(posedge i_clk);
    if (kind == 0) wr_valid <= 1'b1;
    else if (kind == 1) upd <= 1'b1;
    else clr <= 1'b1;
    @(posedge i_clk);
    wr_valid <= 1'b0;
    upd <= 1'b0;
    clr <= 1'b0;
    @(posedge i_clk);
    chk("ready and busy", {14'h0000, rdy, busy}, 16'h0001);
    settle();
  endtask
  task automatic wr(input logic [1:0] c, input logic [9:0] d, input logic g, input logic s);
    @(posedge i_clk);
    chan <= c;
    data <= d;
    gain <= g;
    sync_mode <= s;
    go(0);
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("ERROR timeout expected done seen running");
      stop_test();
    end
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    chk("idle pins", {9'h000, busy, ubs, cs_n, wr_n, upd_n, clr_n, pd_n}, 16'h001F);
    for (int k = 0; k < 4; k++) chk("dac at reset", 16'(u_dev.dac_q[k]), 16'h0000);
    $display("test reset done");
    for (int k = 0; k < 4; k++) wr(2'(k), VALS[k], GAINS[k], 1'b0);
    for (int k = 0; k < 4; k++) begin
      chk("input reg", u_dev.in_q[k], 16'(VALS[k]));
      chk("input gain", 16'(u_dev.gin_q[k]), 16'(GAINS[k]));
      chk("dac held", 16'(u_dev.dac_q[k]), 16'h0000);
    end
    go(1);
    for (int k = 0; k < 4; k++) begin
      chk("dac loaded", 16'(u_dev.dac_q[k]), 16'(VALS[k]));
      chk("gain loaded", 16'(u_dev.gain_q[k]), 16'(GAINS[k]));
    end
    chk("reload count", 16'(u_dev.n_reload), 16'h0004);
    $display("test async load done");
    wr(2'h1, 10'h0F0, 1'b0, 1'b0);
    chk("gain not yet", 16'(u_dev.gain_q[1]), 16'h0001);
    go(1);
    chk("one reload", 16'(u_dev.n_reload), 16'h0005);
    chk("dac b", 16'(u_dev.dac_q[1]), 16'h00F0);
    wr(2'h2, 10'h123, 1'b1, 1'b1);
    chk("sync dac c", 16'(u_dev.dac_q[2]), 16'h0123);
    chk("sync gain c", 16'(u_dev.gain_q[2]), 16'h0001);
    $display("test selective and sync load done");
    // clock enable low must hold the power pin where it was
    ce <= 1'b0;
    pdn <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk("frozen pd pin", {15'h0000, pd_n}, 16'h0001);
    ce <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk("pd pin", {15'h0000, pd_n}, 16'h0000);
    chk("outputs off", {15'h0000, u_dev.out_hiz}, 16'h0001);
    pdn <= 1'b0;
    @(posedge i_clk);
    chk("asleep", {15'h0000, awake}, 16'h0000);
    base = 0;
    while (awake !== 1'b1 && base < 12) begin
      @(posedge i_clk);
      base++;
    end
    chk("awake", {15'h0000, awake}, 16'h0001);
    chk("wake cycles", 16'(base), 16'(WAKE_SIM));
    chk("kept d", 16'(u_dev.dac_q[3]), 16'(VALS[3]));
    chk("kept c", 16'(u_dev.in_q[2]), 16'h0123);
    $display("test power-down done");
    go(2);
    for (int k = 0; k < 4; k++) begin
      chk("cleared dac", 16'(u_dev.dac_q[k]), 16'h0000);
      chk("cleared input", 16'(u_dev.in_q[k]), 16'h0000);
    end
    $display("test clear done");
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
